// ### hw/pwrseq_dev.sv
// modem side power-on sequencer
`timescale 1ns/10ps
`include "pwrseq_defines.svh"
module pwrseq_dev (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RSTN,
  // link to host
  pwrseq_if.dev     LINK,
  // supply and rtc
  input  wire logic MAIN_SUPPLY_OK,
  input  wire logic BACKUP_SUPPLY_OK,
  input  wire logic ALARM_ARM,
  input  wire logic [7:0] ALARM_TIME,
  input  wire logic GREET_EN,
  input  wire logic FIXED_BAUD,
  input  wire logic SHUTDOWN,
  input  wire logic USB_ENUM_DONE,
  output logic      RTC_BACKUP_SUPPLY,
  output logic [7:0] RTC_TIME,
  output logic      IDLE_WAKE,
  output logic      CORE_RESET_N
);
  pwrseq_pkg::dev_state_t state_q;
  logic       pwr_q, rst_q;
  logic [7:0] pulse_cnt_q;
  logic [7:0] cnt_q;
  logic [2:0] pin_idx_q;
  logic [7:0] rtc_div_q;
  logic [7:0] wake_cnt_q;
  logic       alarm_hit;
  logic       pulse_ok;
  logic       pwr_rel, rst_rel;
  logic       cfg_phase;

  assign pwr_rel  = ~pwr_q & LINK.power_on_req_n;
  assign rst_rel  = ~rst_q & LINK.reset_n;
  assign pulse_ok = pulse_cnt_q >= 8'(`PULSE_MIN_CYC);
  assign alarm_hit = ALARM_ARM & (RTC_TIME == ALARM_TIME) & (rtc_div_q == 8'h00);
  // a supply drop must tri-state the pins in the same cycle as the io supply
  assign cfg_phase = MAIN_SUPPLY_OK && (state_q inside {pwrseq_pkg::CFG_PINS,
                     pwrseq_pkg::CFG_USB, pwrseq_pkg::READY_ST});

  // rtc kept alive on backup alone
  assign RTC_BACKUP_SUPPLY = MAIN_SUPPLY_OK | BACKUP_SUPPLY_OK;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_q <= 1'b1;
      rst_q <= 1'b1;
    end else begin
      // last sampled line levels, for release detection
      pwr_q <= LINK.power_on_req_n;
      rst_q <= LINK.reset_n;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pulse_cnt_q <= 8'h00;
    end else if (LINK.power_on_req_n) begin
      pulse_cnt_q <= 8'h00;
    // saturates, so a very long hold still counts as a valid pulse
    end else if (pulse_cnt_q != 8'hFF) begin
      pulse_cnt_q <= pulse_cnt_q + 8'h01;
    end
  end

  // rtc ticks for alarms and idle wake
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rtc_div_q  <= 8'h00;
      RTC_TIME   <= 8'h00;
      wake_cnt_q <= 8'h00;
      IDLE_WAKE  <= 1'b0;
    // either supply keeps time, so an alarm survives a main supply loss
    end else if (RTC_BACKUP_SUPPLY) begin
      rtc_div_q <= (rtc_div_q == 8'(`RTC_DIV_CYC - 1)) ? 8'h00 : rtc_div_q + 8'h01;
      if (rtc_div_q == 8'(`RTC_DIV_CYC - 1)) begin
        RTC_TIME <= RTC_TIME + 8'h01;
      end
      wake_cnt_q <= (wake_cnt_q == 8'(`WAKE_CYC - 1)) ? 8'h00 : wake_cnt_q + 8'h01;
      IDLE_WAKE  <= (state_q == pwrseq_pkg::READY_ST) && (wake_cnt_q == 8'(`WAKE_CYC - 1));
    end else begin
      IDLE_WAKE <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q   <= pwrseq_pkg::NOT_POWERED;
      cnt_q     <= 8'h00;
      pin_idx_q <= 3'h0;
    end else if (!MAIN_SUPPLY_OK) begin
      state_q <= pwrseq_pkg::NOT_POWERED;
      cnt_q   <= 8'h00;
    end else begin
      case (state_q)
        pwrseq_pkg::NOT_POWERED: begin
          if (!LINK.power_on_req_n || !LINK.reset_n) begin
            state_q <= pwrseq_pkg::WAIT_REL;
          end else begin
            // both lines high at supply rise: switch on at once
            state_q <= pwrseq_pkg::IO_UP;
          end
          cnt_q <= 8'h00;
        end
        pwrseq_pkg::WAIT_REL: begin
          if (LINK.power_on_req_n && LINK.reset_n) begin
            state_q <= pwrseq_pkg::IO_UP;
          end
        end
        pwrseq_pkg::OFF_STATE: begin
          // a pulse shorter than the minimum is ignored
          // switch-on events
          if ((pwr_rel && pulse_ok) || rst_rel || alarm_hit) begin
            state_q <= pwrseq_pkg::IO_UP;
          end
          cnt_q <= 8'h00;
        end
        pwrseq_pkg::IO_UP: begin
          // reset held after io supply on
          if (cnt_q == 8'(`RST_HOLD_CYC - 1)) begin
            state_q   <= pwrseq_pkg::CFG_PINS;
            cnt_q     <= 8'h00;
            pin_idx_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        pwrseq_pkg::CFG_PINS: begin
          if (cnt_q == 8'(`PIN_CFG_CYC - 1)) begin
            cnt_q     <= 8'h00;
            pin_idx_q <= pin_idx_q + 3'h1;
            if (pin_idx_q == 3'(`NUM_PINS - 1)) begin
              state_q <= pwrseq_pkg::CFG_USB;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        pwrseq_pkg::CFG_USB: begin
          // timeout, so a silent usb host cannot stall the ready report
          // usb enumeration ends configuration
          if (USB_ENUM_DONE || cnt_q == 8'(`USB_ENUM_CYC - 1)) begin
            state_q <= pwrseq_pkg::READY_ST;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        pwrseq_pkg::READY_ST: begin
          // only shutdown leaves ready here; a supply loss is caught above
          if (SHUTDOWN) begin
            state_q <= pwrseq_pkg::OFF_STATE;
          end
        end
        default: state_q <= pwrseq_pkg::NOT_POWERED;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LINK.io_supply_on <= 1'b0;
      CORE_RESET_N      <= 1'b0;
      LINK.pin_oe       <= 4'h0;
      LINK.pin_o        <= 4'h0;
      LINK.dev_ready    <= 1'b0;
    end else begin
      // registered, so the host watches a clean level
      // io supply only while on
      LINK.io_supply_on <= MAIN_SUPPLY_OK && (state_q inside {pwrseq_pkg::IO_UP,
                           pwrseq_pkg::CFG_PINS, pwrseq_pkg::CFG_USB, pwrseq_pkg::READY_ST});
      // released only after io supply is up
      CORE_RESET_N <= cfg_phase;
      if (!cfg_phase) begin
        LINK.pin_oe <= 4'h0;
        LINK.pin_o  <= 4'h0;
      end else if (state_q == pwrseq_pkg::CFG_PINS && cnt_q == 8'(`PIN_CFG_CYC - 1)) begin
        LINK.pin_oe[pin_idx_q[1:0]] <= 1'b1;
        LINK.pin_o[pin_idx_q[1:0]]  <= 1'b1;
      end
      LINK.dev_ready <= (state_q == pwrseq_pkg::READY_ST) && MAIN_SUPPLY_OK && !SHUTDOWN;
    end
  end

  // autobaud leaves the line rate unknown, so no greeting is sent then
  // greeting only at fixed baud
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LINK.greeting <= 1'b0;
    end else begin
      // first ready cycle only, so the pulse rises together with ready
      LINK.greeting <= GREET_EN && FIXED_BAUD && MAIN_SUPPLY_OK && !SHUTDOWN
                       && (state_q == pwrseq_pkg::READY_ST) && !LINK.dev_ready;
    end
  end
endmodule : pwrseq_dev

// ### include/pwrseq_defines.svh
// timing constants and rule summary for the power-on sequencer
// Functional notes
// - backup domain on whenever main supply valid
// - io supply output only while switched on
// - no switch-on without valid main supply
// - held line at supply rise: start on release
// - power-on low pulse released starts switch-on
// - reset line rising edge starts switch-on
// - rtc alarm starts switch-on from off
// - power-on and reset inputs pulled high internally
// - digital pins tri-stated until io supply on
// - internal reset holds core and pins
// - pins configured in order after reset release
// - ready only after all interfaces configured; the code also reports ready when the usb enumeration wait times out
// - greeting only when enabled and fixed baud
// - host infers switch-on from io supply rise
// - host drives no pins before io supply on
// - host sends no command before ready
// - rtc runs while backup domain valid
// - rtc times idle wake-ups and alarms
`ifndef PWRSEQ_DEFINES_SVH
`define PWRSEQ_DEFINES_SVH
`define CLK_NS          40
`define PULSE_MIN_NS    1000
`define PULSE_MIN_CYC   ((`PULSE_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_HOLD_CYC    8
`define PIN_CFG_CYC     4
`define USB_ENUM_CYC    64
`define NUM_PINS        4
`define RTC_DIV_CYC     16
`define WAKE_CYC        32
`endif

// ### include/pwrseq_pkg.sv
// types shared by both ends of the power-on sequencer
package pwrseq_pkg;
  typedef enum logic [6:0] {
    NOT_POWERED = 7'h01,
    OFF_STATE   = 7'h02,
    WAIT_REL    = 7'h04,
    IO_UP       = 7'h08,
    CFG_PINS    = 7'h10,
    CFG_USB     = 7'h20,
    READY_ST    = 7'h40
  } dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_PULSE = 4'h2,
    H_WAIT  = 4'h4,
    H_READY = 4'h8
  } host_state_t;
endpackage : pwrseq_pkg

// ### include/pwrseq_if.sv
// link between the modem power-on logic and the host
`timescale 1ns/10ps
interface pwrseq_if;
  logic       power_on_req_n_o;
  logic       power_on_req_n_oe;
  logic       reset_n_o;
  logic       reset_n_oe;
  logic       io_supply_on;
  logic       dev_ready;
  logic       greeting;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  // pull-ups resolve undriven lines high
  wire power_on_req_n = power_on_req_n_oe ? power_on_req_n_o : 1'b1;
  wire reset_n        = reset_n_oe ? reset_n_o : 1'b1;
  modport dev  (input power_on_req_n, input reset_n, output io_supply_on,
                output dev_ready, output greeting, output pin_o, output pin_oe);
  modport host (output power_on_req_n_o, output power_on_req_n_oe, output reset_n_o,
                output reset_n_oe, input io_supply_on, input dev_ready, input greeting,
                input pin_o, input pin_oe);
endinterface : pwrseq_if

// ### hw/pwrseq_host.sv
// host side power-on driver
`timescale 1ns/10ps
`include "pwrseq_defines.svh"
module pwrseq_host (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RSTN,
  // link to modem
  pwrseq_if.host    LINK,
  // user side
  input  wire logic POWER_UP_REQ,
  input  wire logic RESET_REQ,
  input  wire logic CMD_VALID,
  output logic      CMD_READY,
  output logic      SWITCHED_ON,
  output logic      MODEM_READY,
  output logic      GREETED
);
  pwrseq_pkg::host_state_t state_q;
  logic [7:0] cnt_q;

  assign CMD_READY = MODEM_READY & LINK.io_supply_on;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q                <= pwrseq_pkg::H_IDLE;
      cnt_q                  <= 8'h00;
      LINK.power_on_req_n_o  <= 1'b1;
      LINK.power_on_req_n_oe <= 1'b0;
      LINK.reset_n_o         <= 1'b1;
      LINK.reset_n_oe        <= 1'b0;
    end else begin
      // reset line held low while requested
      LINK.reset_n_o  <= 1'b0;
      LINK.reset_n_oe <= RESET_REQ;
      case (state_q)
        pwrseq_pkg::H_IDLE: begin
          if (POWER_UP_REQ && !LINK.io_supply_on) begin
            state_q                <= pwrseq_pkg::H_PULSE;
            cnt_q                  <= 8'h00;
            LINK.power_on_req_n_o  <= 1'b0;
            LINK.power_on_req_n_oe <= 1'b1;
          end
        end
        pwrseq_pkg::H_PULSE: begin
          if (cnt_q == 8'(`PULSE_MIN_CYC + 1)) begin
            LINK.power_on_req_n_oe <= 1'b0;
            LINK.power_on_req_n_o  <= 1'b1;
            state_q                <= pwrseq_pkg::H_WAIT;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        pwrseq_pkg::H_WAIT: begin
          if (LINK.dev_ready) begin
            state_q <= pwrseq_pkg::H_READY;
          end
        end
        pwrseq_pkg::H_READY: begin
          if (!LINK.io_supply_on) begin
            state_q <= pwrseq_pkg::H_IDLE;
          end
        end
        default: state_q <= pwrseq_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SWITCHED_ON <= 1'b0;
      MODEM_READY <= 1'b0;
      GREETED     <= 1'b0;
    end else begin
      SWITCHED_ON <= LINK.io_supply_on;
      MODEM_READY <= LINK.dev_ready && LINK.io_supply_on;
      GREETED <= LINK.io_supply_on && (GREETED || LINK.greeting);
    end
  end
endmodule : pwrseq_host

// ### test/pwrseq_monitor.sv
// concurrent checks on the host to modem power link
`timescale 1ns/10ps
module pwrseq_monitor (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // link signals
  input wire logic       power_on_req_n,
  input wire logic       reset_n,
  input wire logic       io_supply_on,
  input wire logic       dev_ready,
  input wire logic       greeting,
  input wire logic [3:0] pin_oe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_io_up; $rose(io_supply_on); endsequence
  sequence s_pins_held; (pin_oe == 4'h0) [*8]; endsequence
  a_pins_tristate: assert property (!io_supply_on |-> pin_oe == 4'h0)
    else $error("pins driven with io supply off");
  a_reset_hold: assert property (s_io_up |-> s_pins_held)
    else $error("pins left reset too early");
  a_start_release: assert property (s_io_up |-> $past(power_on_req_n) && $past(reset_n))
    else $error("switch-on while a line was held low");
  a_pin_order: assert property (pin_oe inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("pins configured out of order");
  a_pin_step: assert property ($rose(pin_oe[0]) |-> ##[3:5] $rose(pin_oe[1]))
    else $error("second pin step late");
  a_ready_bound: assert property ($rose(pin_oe[3]) |-> ##[1:80] dev_ready)
    else $error("ready not reached after pins");
  a_ready_pins: assert property (dev_ready |-> pin_oe == 4'hF && io_supply_on)
    else $error("ready before all pins configured");
  a_greet_entry: assert property (greeting |-> $rose(dev_ready))
    else $error("greeting away from ready entry");
  a_off_drop: assert property ($fell(io_supply_on) |-> !dev_ready)
    else $error("ready kept with io supply off");
endmodule : pwrseq_monitor

// ### test/module_power_on_sequencer_test.sv
// self-checking bench for the power-on sequencer pair
`timescale 1ns/10ps
module module_power_on_sequencer_test;
  logic       clk, rstn, main_ok, bkp_ok, arm, greet_en, fixed_baud;
  logic       shut, usb_done, up_req, rst_req, cmd_valid;
  logic [7:0] alarm_t, rtc_time, t0;
  logic       rtc_bkp, idle_wake, core_rst_n, cmd_ready, sw_on, mdm_ready, greeted;
  int         n_fail, checked, cyc, greets, wakes, w0;
  pwrseq_if link ();
  pwrseq_dev pwrseq_dev_inst (.CLK(clk), .RSTN(rstn), .LINK(link), .MAIN_SUPPLY_OK(main_ok),
    .BACKUP_SUPPLY_OK(bkp_ok), .ALARM_ARM(arm), .ALARM_TIME(alarm_t), .GREET_EN(greet_en),
    .FIXED_BAUD(fixed_baud), .SHUTDOWN(shut), .USB_ENUM_DONE(usb_done),
    .RTC_BACKUP_SUPPLY(rtc_bkp), .RTC_TIME(rtc_time), .IDLE_WAKE(idle_wake),
    .CORE_RESET_N(core_rst_n));
  pwrseq_host pwrseq_host_inst (.CLK(clk), .RSTN(rstn), .LINK(link), .POWER_UP_REQ(up_req),
    .RESET_REQ(rst_req), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .SWITCHED_ON(sw_on), .MODEM_READY(mdm_ready), .GREETED(greeted));
  pwrseq_monitor pwrseq_monitor_inst (.CLK(clk), .RSTN(rstn),
    .power_on_req_n(link.power_on_req_n), .reset_n(link.reset_n),
    .io_supply_on(link.io_supply_on), .dev_ready(link.dev_ready),
    .greeting(link.greeting), .pin_oe(link.pin_oe));
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  // outputs are read at the falling edge, well clear of updates
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // sel 0 waits for io supply, sel 1 for host ready
  task automatic wait_hi(input bit sel, input int n);
    int i;
    for (i = 0; i < n && (sel ? mdm_ready : link.io_supply_on) !== 1'h1; i++) tick(1);
    chk({7'h00, sel ? mdm_ready : link.io_supply_on}, 8'h01);
  endtask : wait_hi
  task automatic go_off();
    @(posedge clk) shut <= 1'h1;
    @(posedge clk) shut <= 1'h0;
    tick(3);
    chk({7'h00, link.io_supply_on}, 8'h00);
    chk({4'h0, link.pin_oe}, 8'h00);
    chk({7'h00, sw_on}, 8'h00);
    chk({7'h00, cmd_ready}, 8'h00);
    chk({7'h00, greeted}, 8'h00);
  endtask : go_off
  task automatic t_cold();
    tick(20);
    chk({7'h00, link.io_supply_on}, 8'h00);
    chk({7'h00, rtc_bkp}, 8'h01);
    @(posedge clk) main_ok <= 1'h1;
    tick(30);
    chk({7'h00, link.io_supply_on}, 8'h00);
    chk({7'h00, link.reset_n}, 8'h00);
    @(posedge clk) rst_req <= 1'h0;
    wait_hi(0, 10);
    chk({4'h0, link.pin_oe}, 8'h00);
    chk({7'h00, core_rst_n}, 8'h00);
    chk({7'h00, cmd_ready}, 8'h00);
    wait_hi(1, 200);
    chk({4'h0, link.pin_oe}, 8'h0F);
    chk({4'h0, link.pin_o}, 8'h0F);
    chk({7'h00, core_rst_n}, 8'h01);
    chk({7'h00, sw_on}, 8'h01);
    chk({7'h00, cmd_ready}, 8'h01);
    chk({7'h00, greeted}, 8'h01);
    chk(8'(greets), 8'h01);
    w0 = wakes;
    tick(64);
    chk(8'(wakes - w0), 8'h02);
  endtask : t_cold
  task automatic t_pulse();
    go_off();
    @(posedge clk) begin
      fixed_baud <= 1'h0;
      usb_done <= 1'h1;
      up_req <= 1'h1;
    end
    tick(15);
    // the long host pulse must not start anything before release
    chk({7'h00, link.io_supply_on}, 8'h00);
    chk({7'h00, link.power_on_req_n}, 8'h00);
    wait_hi(0, 40);
    @(posedge clk) up_req <= 1'h0;
    wait_hi(1, 200);
    chk(8'(greets), 8'h01);
    chk({7'h00, greeted}, 8'h00);
  endtask : t_pulse
  task automatic t_edge();
    go_off();
    @(posedge clk) begin
      greet_en <= 1'h0;
      fixed_baud <= 1'h1;
      rst_req <= 1'h1;
    end
    tick(10);
    chk({7'h00, link.io_supply_on}, 8'h00);
    @(posedge clk) rst_req <= 1'h0;
    wait_hi(0, 10);
    wait_hi(1, 200);
    chk(8'(greets), 8'h01);
  endtask : t_edge
  task automatic t_alarm();
    go_off();
    t0 = rtc_time;
    tick(40);
    chk({7'h00, rtc_time !== t0}, 8'h01);
    @(posedge clk) begin
      alarm_t <= rtc_time + 8'h02;
      arm <= 1'h1;
      greet_en <= 1'h1;
    end
    wait_hi(0, 80);
    @(posedge clk) arm <= 1'h0;
    wait_hi(1, 200);
    chk(8'(greets), 8'h02);
    chk({7'h00, greeted}, 8'h01);
  endtask : t_alarm
  task automatic t_drop();
    @(posedge clk) main_ok <= 1'h0;
    tick(3);
    chk({7'h00, link.io_supply_on}, 8'h00);
    chk({4'h0, link.pin_oe}, 8'h00);
    chk({7'h00, rtc_bkp}, 8'h01);
    @(posedge clk) bkp_ok <= 1'h0;
    tick(2);
    chk({7'h00, rtc_bkp}, 8'h00);
    // power-on held low by the host while main supply comes back
    @(posedge clk) up_req <= 1'h1;
    tick(6);
    chk({7'h00, link.power_on_req_n}, 8'h00);
    @(posedge clk) main_ok <= 1'h1;
    tick(8);
    chk({7'h00, link.io_supply_on}, 8'h00);
    wait_hi(0, 40);
    chk({7'h00, rtc_bkp}, 8'h01);
    @(posedge clk) up_req <= 1'h0;
  endtask : t_drop
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    greets += link.greeting;
    wakes += idle_wake;
  end
  // whole run needs about 500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    {rstn, main_ok, arm, shut, usb_done, up_req, cmd_valid} = 7'h00;
    {bkp_ok, greet_en, fixed_baud, rst_req} = 4'hF;
    alarm_t = 8'h00;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    t_cold();
    t_pulse();
    t_edge();
    t_alarm();
    t_drop();
    tally_and_finish();
  end
endmodule : module_power_on_sequencer_test
